// ---- hw/lsep_pkg.sv ----
// Constants, carriers and enumerations for the LED, strap and event pin block.
// Assumes a single 50 MHz clock and a synchronous active high reset.
// How it works
// - LED pin low lights, high darkens
// - Link steady, activity blinks, combined on/blink
// - Speed LED lit at 100, dark at 10
// - First LED pin strap picks bus width
// - EEPROM data pin strap flags EEPROM presence
// - Strap pins input in reset; afterwards the LED pin is output, the EEPROM pin only while eeprom_tx_en
// - Enabled wake event asserts wake output
// - Wake output polarity programmable, default low
// - Interrupt pin pulled low, never driven high
package lsep_pkg;

  // Clock rate and LED timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int BLINK_HALF_MS  = 50;   // Half period of the activity blink
  localparam int ACT_HOLD_MS    = 100;  // Blink kept alive after each activity pulse
  localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int ACT_HOLD_CYC   = (CLK_HZ / 1000) * ACT_HOLD_MS;

  // Register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WAKE_W = 4;
  localparam int IRQ_W  = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] OFS_POWER_CTRL  = 8'h04;
  localparam logic [7:0] OFS_WAKE_STAT   = 8'h08;
  localparam logic [7:0] OFS_WAKE_CLR    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN      = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR     = 8'h18;
  localparam logic [7:0] OFS_PIN_STAT    = 8'h1C;

  // Field positions
  localparam int GCR_LED_SEL  = 9;  // LED meaning select
  localparam int PMR_POLARITY = 8;  // Wake output polarity, 1 = active high
  localparam int IRQ_LINK     = 0;  // Link changed
  localparam int IRQ_SPEED    = 1;  // Speed changed
  localparam int IRQ_WAKE     = 2;  // New wake event
  localparam int PIN_BUS16    = 0;
  localparam int PIN_EEPROM   = 1;
  localparam int PIN_LINK     = 2;
  localparam int PIN_SPEED    = 3;
  localparam int PIN_LED1_LIT = 4;
  localparam int PIN_LED2_LIT = 5;
  localparam int PIN_RD_LOW   = 6;
  localparam int PIN_WR_LOW   = 7;

  // Reset values
  localparam logic [15:0] GCR_RST = 16'h0000;
  localparam logic [15:0] PMR_RST = 16'h0000;

  // Port state from the PHY side, same clock
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic activity;   // One cycle pulse per frame
  } lsep_link_s;

  // One register bus request
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lsep_bus_s;

  // Strap capture sequence
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RUN
  } lsep_strap_e;

endpackage

// ---- hw/lsep_sync.sv ----
// Two flop synchroniser for pin inputs, any width.
// Assumes the inputs are asynchronous levels; no reset so pins track during reset.
`timescale 1ns/1ns
module lsep_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // First stage, read only by the second

  // Two stages; the output is the second flop
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ---- hw/lsep_blink.sv ----
// Activity blink generator: free phase toggle plus an activity hold timer.
// Assumes activity pulses arrive on the same clock.
`timescale 1ns/1ns
module lsep_blink #(
  parameter int HALF_CYC = 2_500_000,
  parameter int HOLD_CYC = 5_000_000
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic act_pulse,
  output logic      phase_q,
  output logic      active_q
);

  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int DW = $clog2(HOLD_CYC + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);
  localparam logic [DW-1:0] HOLD_LOAD = DW'(HOLD_CYC);

  logic [HW-1:0] half_q;  // Cycles into the current half period
  logic [DW-1:0] hold_q;  // Cycles of blinking left

  wire half_end = (half_q == HALF_LAST);  // Last cycle of a half period

  // Phase counter and toggle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      half_q  <= '0;
      phase_q <= 1'b0;
    end else if (ce) begin
      half_q  <= half_end ? '0 : half_q + HW'(1);
      phase_q <= half_end ? ~phase_q : phase_q;
    end
  end

  // Each pulse restarts the hold; blinking lasts while it runs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_q   <= '0;
      active_q <= 1'b0;
    end else if (ce) begin
      hold_q   <= act_pulse ? HOLD_LOAD : (hold_q != '0 ? hold_q - DW'(1) : '0);
      active_q <= act_pulse || (hold_q > DW'(1));
    end
  end

endmodule

// ---- hw/lsep_top.sv ----
// LED, strap, wake event and interrupt pin logic with its register file.
// Assumes PHY status and wake events come from logic on ref_clk; pins and
// host strobes are asynchronous and are synchronised here.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module lsep_top #(
  parameter int BLINK_HALF = lsep_pkg::BLINK_HALF_CYC,  // Blink half period, cycles
  parameter int ACT_HOLD   = lsep_pkg::ACT_HOLD_CYC     // Activity hold, cycles
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  input  wire lsep_pkg::lsep_bus_s          bus,
  output logic      [lsep_pkg::DATA_W-1:0]  rd_data,
  input  wire lsep_pkg::lsep_link_s         link,
  input  wire logic [lsep_pkg::WAKE_W-1:0]  wake_events,
  input  wire logic                         eeprom_tx_data,
  input  wire logic                         eeprom_tx_en,
  output logic                              eeprom_rx_data,
  input  wire logic                         port_led_first_i,
  output logic                              port_led_first_o,
  output logic                              port_led_first_oe,
  output logic                              port_led_second_o,
  input  wire logic                         eeprom_serial_data_i,
  output logic                              eeprom_serial_data_o,
  output logic                              eeprom_serial_data_oe,
  input  wire logic                         read_strobe_n,
  input  wire logic                         write_strobe_n,
  output logic                              host_read_active,
  output logic                              host_write_active,
  output logic                              wake_event_out,
  output logic                              host_irq_n_o,
  output logic                              host_irq_n_oe,
  output logic                              strap_bus_16,
  output logic                              strap_eeprom_present
);
  import lsep_pkg::*;

  // Synchronised pins: LED strap, EEPROM data, read and write strobes
  logic [3:0] pin_s;
  wire        led1_s = pin_s[0];
  wire        eed_s  = pin_s[1];
  wire        rdn_s  = pin_s[2];
  wire        wrn_s  = pin_s[3];

  lsep_sync #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .ce      (ce),
    .d       ({write_strobe_n, read_strobe_n, eeprom_serial_data_i, port_led_first_i}),
    .q       (pin_s)
  );

  // Blink phase and activity hold
  logic blink_phase;
  logic act_active;

  lsep_blink #(.HALF_CYC(BLINK_HALF), .HOLD_CYC(ACT_HOLD)) u_blink (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .act_pulse (link.activity),
    .phase_q   (blink_phase),
    .active_q  (act_active)
  );

  // Registers
  lsep_strap_e       state_q;        // Strap sequence state
  logic              bus16_q;        // Captured bus width strap
  logic              eeprom_q;       // Captured EEPROM presence strap
  logic [DATA_W-1:0] gcr_q;          // global_control_reg
  logic [DATA_W-1:0] pmr_q;          // power_event_control_reg
  logic [WAKE_W-1:0] wake_stat_q;    // Sticky wake events
  logic [IRQ_W-1:0]  irq_stat_q;     // Sticky interrupt events
  logic [IRQ_W-1:0]  irq_en_q;       // Interrupt enables
  logic              link_q;         // Previous link level
  logic              speed_q;        // Previous speed level
  logic [DATA_W-1:0] rd_data_q;      // Read data, one cycle after strobe
  logic              led1_n_q;       // First LED pin level
  logic              led1_oe_q;      // First LED pin enable
  logic              led2_n_q;       // Second LED pin level
  logic              eed_o_q;        // EEPROM data pin level
  logic              eed_oe_q;       // EEPROM data pin enable
  logic              eed_rx_q;       // EEPROM data toward the core
  logic              rd_act_q;       // Host read strobe held low
  logic              wr_act_q;       // Host write strobe held low
  logic              wake_q;         // Wake pin level
  logic              irq_oe_q;       // Interrupt pin pulled low

  // Address decode
  wire wr_gcr   = bus.wr && (bus.addr == OFS_GLOBAL_CTRL);
  wire wr_pmr   = bus.wr && (bus.addr == OFS_POWER_CTRL);
  wire wr_wclr  = bus.wr && (bus.addr == OFS_WAKE_CLR);
  wire wr_ien   = bus.wr && (bus.addr == OFS_IRQ_EN);
  wire wr_iclr  = bus.wr && (bus.addr == OFS_IRQ_CLR);
  wire running  = (state_q == ST_RUN);

  // LED meanings from port status and blink
  wire led_sel     = gcr_q[GCR_LED_SEL];
  wire blink_dark  = act_active && blink_phase;          // Blink off half
  wire act_lit     = act_active && !blink_phase;
  wire link_lit    = link.link_up;
  wire linkact_lit = link.link_up && !blink_dark;
  wire speed_lit   = link.speed_100;
  wire first_lit   = led_sel ? act_lit  : speed_lit;
  wire second_lit  = led_sel ? link_lit : linkact_lit;

  // Event sources
  wire [WAKE_W-1:0] wake_en   = pmr_q[WAKE_W-1:0];
  wire [WAKE_W-1:0] wake_hit  = wake_events & wake_en;
  wire              wake_pend = |(wake_stat_q & wake_en);
  wire              wake_pol  = pmr_q[PMR_POLARITY];
  wire [IRQ_W-1:0]  irq_evt;
  assign irq_evt[IRQ_LINK]  = running && (link.link_up != link_q);
  assign irq_evt[IRQ_SPEED] = running && (link.speed_100 != speed_q);
  assign irq_evt[IRQ_WAKE]  = |wake_hit;
  wire              irq_pend = |(irq_stat_q & irq_en_q);

  // Pin status word
  wire [DATA_W-1:0] pin_word = {8'h00, ~wrn_s, ~rdn_s, ~led2_n_q, ~led1_n_q,
                                link.speed_100, link.link_up, eeprom_q, bus16_q};

  // Read multiplexer; unmapped and write-only offsets read zero
  wire [DATA_W-1:0] rd_mux =
      (bus.addr == OFS_GLOBAL_CTRL) ? gcr_q :
      (bus.addr == OFS_POWER_CTRL)  ? pmr_q :
      (bus.addr == OFS_WAKE_STAT)   ? {{(DATA_W-WAKE_W){1'b0}}, wake_stat_q} :
      (bus.addr == OFS_IRQ_STAT)    ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q} :
      (bus.addr == OFS_IRQ_EN)      ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_q} :
      (bus.addr == OFS_PIN_STAT)    ? pin_word : 16'h0000;

  // Strap sequence: hold while reset, run after the release cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_HOLD;
    end else if (ce) begin
      case (state_q)
        ST_HOLD: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // Strap capture in the first cycle after release, then frozen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus16_q  <= 1'b0;
      eeprom_q <= 1'b0;
    end else if (ce && !running) begin
      bus16_q  <= led1_s;
      eeprom_q <= eed_s;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gcr_q    <= GCR_RST;
      pmr_q    <= PMR_RST;
      irq_en_q <= '0;
    end else if (ce) begin
      if (wr_gcr) begin
        gcr_q <= bus.wdata;
      end
      if (wr_pmr) begin
        pmr_q <= bus.wdata;
      end
      if (wr_ien) begin
        irq_en_q <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_stat_q <= '0;
      irq_stat_q  <= '0;
    end else if (ce) begin
      wake_stat_q <= (wake_stat_q & ~(wr_wclr ? bus.wdata[WAKE_W-1:0] : '0)) | wake_hit;
      irq_stat_q  <= (irq_stat_q & ~(wr_iclr ? bus.wdata[IRQ_W-1:0] : '0)) | irq_evt;
    end
  end

  // Previous port levels and read data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_q    <= 1'b0;
      speed_q   <= 1'b0;
      rd_data_q <= '0;
    end else if (ce) begin
      link_q    <= link.link_up;
      speed_q   <= link.speed_100;
      rd_data_q <= bus.rd ? rd_mux : '0;
    end
  end

  // LED pins: low lights; first LED only drives once straps are taken
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      led1_n_q  <= 1'b1;
      led1_oe_q <= 1'b0;
      led2_n_q  <= 1'b1;
    end else if (ce) begin
      led1_n_q  <= ~first_lit;
      led1_oe_q <= running;
      led2_n_q  <= ~second_lit;
    end
  end

  // EEPROM data pin: input in reset, core drives it afterwards only while eeprom_tx_en
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      eed_o_q  <= 1'b0;
      eed_oe_q <= 1'b0;
      eed_rx_q <= 1'b0;
    end else if (ce) begin
      eed_o_q  <= eeprom_tx_data;
      eed_oe_q <= running && eeprom_tx_en;
      eed_rx_q <= eed_s;
    end
  end

  // Host strobes, wake and interrupt pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      wake_q   <= 1'b1;
      irq_oe_q <= 1'b0;
    end else if (ce) begin
      rd_act_q <= ~rdn_s;
      wr_act_q <= ~wrn_s;
      wake_q   <= wake_pend ~^ wake_pol;
      irq_oe_q <= irq_pend;
    end
  end

  // Outputs
  assign rd_data               = rd_data_q;
  assign port_led_first_o      = led1_n_q;
  assign port_led_first_oe     = led1_oe_q;
  assign port_led_second_o     = led2_n_q;
  assign eeprom_serial_data_o  = eed_o_q;
  assign eeprom_serial_data_oe = eed_oe_q;
  assign eeprom_rx_data        = eed_rx_q;
  assign host_read_active      = rd_act_q;
  assign host_write_active     = wr_act_q;
  assign wake_event_out        = wake_q;
  assign host_irq_n_o          = 1'b0;
  assign host_irq_n_oe         = irq_oe_q;
  assign strap_bus_16          = bus16_q;
  assign strap_eeprom_present  = eeprom_q;

  // Checks; LED pins lag their causes by one cycle
  a_led1_polarity: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    running && ce && first_lit |=> !port_led_first_o)
    else $error("first LED not low while lit");
  a_led_select: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !led_sel && link.link_up && !link.speed_100 |=>
      port_led_first_o && (!port_led_second_o || $past(blink_dark)))
    else $error("default LED meaning wrong");
  a_link_steady: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    led_sel && link.link_up |=> !port_led_second_o)
    else $error("link LED not steady on");
  a_speed_led: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !led_sel && !link.speed_100 ##1 !led_sel && !link.speed_100 |=> port_led_first_o)
    else $error("speed LED lit at ten");
  a_strap_held: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    running && $past(running) |-> $stable(bus16_q) && $stable(eeprom_q))
    else $error("strap changed after capture");
  a_strap_take: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !running |=> bus16_q == $past(led1_s) && eeprom_q == $past(eed_s))
    else $error("strap not captured at release");
  a_strap_input: assert property (@(posedge ref_clk)
    reset ##1 reset |-> !port_led_first_oe && !eeprom_serial_data_oe)
    else $error("strap pin driven during reset");
  a_wake_level: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    wake_pend |=> wake_event_out == $past(wake_pol))
    else $error("wake output not asserted");
  a_wake_default: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !wake_pend && !wake_pol |=> wake_event_out)
    else $error("wake output not idle high");
  a_irq_pull: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    irq_pend |=> host_irq_n_oe && !host_irq_n_o)
    else $error("interrupt pin not pulled low");
  a_irq_idle: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !irq_pend |=> !host_irq_n_oe)
    else $error("interrupt pin held without cause");
  a_read_follow: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !rdn_s |=> host_read_active)
    else $error("read strobe not reported");
  a_write_follow: assert property (@(posedge ref_clk) disable iff (reset || !ce)
    !wrn_s |=> host_write_active)
    else $error("write strobe not reported");
  // Main scenarios the bench should reach
  c_wake_event: cover property (@(posedge ref_clk) disable iff (reset) wake_pend ##1 !wake_pend);
  c_strap_16: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(running) && strap_bus_16);
  c_irq_clear: cover property (@(posedge ref_clk) disable iff (reset) host_irq_n_oe ##1 wr_iclr);
  c_blink: cover property (@(posedge ref_clk) disable iff (reset) led_sel && act_lit ##1 blink_dark);

endmodule

// ---- verification/lsep_board.sv ----
// Board and host model around the pin block: pulls on the strap and
// interrupt pins, and the host processor's asynchronous strobes.
// Assumes the bench raises host_rd or host_wr for as long as a cycle lasts.
`timescale 1ns/1ns
module lsep_board (
  input  wire logic pull_led,        // Board strap level on the first LED pin
  input  wire logic pull_ee,         // Board strap level on the EEPROM data pin
  input  wire logic led_o,
  input  wire logic led_oe,
  input  wire logic ee_o,
  input  wire logic ee_oe,
  input  wire logic irq_o,
  input  wire logic irq_oe,
  input  wire logic host_rd,         // Host wants a read cycle
  input  wire logic host_wr,         // Host wants a write cycle
  output logic      led_pin,
  output logic      ee_pin,
  output logic      irq_pin,
  output logic      read_strobe_n,
  output logic      write_strobe_n
);
  // Released strap pins fall back to their board pull
  assign led_pin = led_oe ? led_o : pull_led;
  assign ee_pin  = ee_oe ? ee_o : pull_ee;
  // Open drain line with its external pull-up
  assign irq_pin = irq_oe ? irq_o : 1'b1;
  // Strobes rest high and go low only for a cycle
  assign read_strobe_n  = ~host_rd;
  assign write_strobe_n = ~host_wr;
endmodule

// ---- verification/test_led_strap_event_pins.sv ----
// Self-checking bench for the LED, strap, wake and interrupt pin block.
// Assumes lsep_board for the pins and short blink and hold counts.
`timescale 1ns/1ns
module test_led_strap_event_pins;
  import lsep_pkg::*;
  localparam int HOLD  = 16;        // Activity hold used in simulation
  localparam int LIMIT = 5000;      // Cycle ceiling of the whole run
  logic ref_clk, reset, ce, tx_data, tx_en, rx_data, host_rd, host_wr;
  logic led_pin, led_o, led_oe, led2_o, ee_pin, ee_o, ee_oe, rd_n, wr_n;
  logic rd_act, wr_act, wake_out, irq_o, irq_oe, irq_pin, s16, see;
  logic pull_led, pull_ee, prev, cur, p;
  lsep_bus_s   bus;
  lsep_link_s  link;
  logic [15:0] rd_data, v;
  logic [3:0]  wake_events, w;
  logic [7:0]  rnd;
  logic [1:0]  e;
  int          mismatches, total_checks, cycles, n;

  lsep_top #(.BLINK_HALF(4), .ACT_HOLD(HOLD)) dut (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .bus(bus), .rd_data(rd_data),
    .link(link), .wake_events(wake_events), .eeprom_tx_data(tx_data),
    .eeprom_tx_en(tx_en), .eeprom_rx_data(rx_data), .port_led_first_i(led_pin),
    .port_led_first_o(led_o), .port_led_first_oe(led_oe),
    .port_led_second_o(led2_o), .eeprom_serial_data_i(ee_pin),
    .eeprom_serial_data_o(ee_o), .eeprom_serial_data_oe(ee_oe),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .host_read_active(rd_act),
    .host_write_active(wr_act), .wake_event_out(wake_out), .host_irq_n_o(irq_o),
    .host_irq_n_oe(irq_oe), .strap_bus_16(s16), .strap_eeprom_present(see));

  lsep_board board (
    .pull_led(pull_led), .pull_ee(pull_ee), .led_o(led_o), .led_oe(led_oe),
    .ee_o(ee_o), .ee_oe(ee_oe), .irq_o(irq_o), .irq_oe(irq_oe), .host_rd(host_rd),
    .host_wr(host_wr), .led_pin(led_pin), .ee_pin(ee_pin), .irq_pin(irq_pin),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n));

  // Free running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Random source of the bench
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected {first, second} LED outputs with no activity; low lights
  function automatic logic [1:0] led_exp(input logic sel, input logic up, input logic spd);
    return sel ? {1'b1, ~up} : {~spd, ~up};
  endfunction

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare one seen value with its expectation
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register write cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  // One register read cycle; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    d = rd_data;
  endtask

  // Let k edges pass, then settle at the falling edge
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Reset with the given strap pulls, checking pins in and after reset
  task automatic do_reset(input logic pl, input logic pe);
    @(posedge ref_clk);
    reset    <= 1'b1;
    pull_led <= pl;
    pull_ee  <= pe;
    tx_en    <= 1'b1;
    tick(5);
    chk(16'({led_oe, ee_oe, irq_oe, wake_out, led2_o}), 16'h0003);
    @(posedge ref_clk);
    reset <= 1'b0;
    tick(3);
    chk(16'({s16, see}), 16'({pl, pe}));
    chk(16'({led_oe, ee_oe}), 16'h0003);
    @(posedge ref_clk);
    tx_en <= 1'b0;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    reset = 1'b1; ce = 1'b1; bus = '0; link = '0; wake_events = '0;
    tx_data = 1'b0; tx_en = 1'b0; host_rd = 1'b0; host_wr = 1'b0;
    pull_led = 1'b1; pull_ee = 1'b0; rnd = 8'h36;
    mismatches = 0; total_checks = 0; cycles = 0;
    // Every strap combination, the last one leaves both high
    for (int k = 0; k < 4; k++) begin
      do_reset(k[0], k[1]);
    end
    // Reset values, a write-only place and an unmapped place
    rd(OFS_GLOBAL_CTRL, v);
    chk(v, GCR_RST);
    rd(OFS_POWER_CTRL, v);
    chk(v, PMR_RST);
    rd(OFS_IRQ_CLR, v);
    chk(v, 16'h0000);
    rd(8'h20, v);
    chk(v, 16'h0000);
    // Pulls flip after capture; the stored straps must not follow
    @(posedge ref_clk);
    pull_ee  <= 1'b0;
    pull_led <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_GLOBAL_CTRL, s ? 16'h0200 : 16'h0000);
      repeat (8) begin
        rnd = lfsr_step(rnd);
        @(posedge ref_clk);
        link.link_up   <= rnd[0];
        link.speed_100 <= rnd[1];
        tick(HOLD + 4);
        e = led_exp(s[0], rnd[0], rnd[1]);
        chk(16'({led_o, led2_o}), 16'(e));
        rd(OFS_PIN_STAT, v);
        chk(16'(v[5:2]), 16'({~e[0], ~e[1], rnd[1], rnd[0]}));
      end
      // One activity pulse over a steady link must make the LED blink
      @(posedge ref_clk);
      link.link_up <= 1'b1;
      tick(3);
      @(posedge ref_clk);
      link.activity <= 1'b1;
      @(posedge ref_clk);
      link.activity <= 1'b0;
      n = 0;
      prev = s ? led_o : led2_o;
      repeat (HOLD) begin
        @(negedge ref_clk);
        cur = s ? led_o : led2_o;
        if (cur !== prev) n++;
        prev = cur;
      end
      chk(16'(n >= 2), 16'h0001);
    end
    chk(16'({s16, see}), 16'h0003);
    // Wake events under both polarities, with interrupt mask and clear
    wr(OFS_IRQ_CLR, 16'h0007);
    wr(OFS_IRQ_EN, 16'h0004);
    for (int q = 0; q < 2; q++) begin
      p = q[0];
      wr(OFS_POWER_CTRL, p ? 16'h010F : 16'h000F);
      tick(2);
      chk(16'(wake_out), 16'({~p}));
      rnd = lfsr_step(rnd);
      w = (rnd[3:0] == 4'h0) ? 4'h1 : rnd[3:0];
      @(posedge ref_clk);
      wake_events <= w;
      @(posedge ref_clk);
      wake_events <= 4'h0;
      tick(2);
      chk(16'(wake_out), 16'(p));
      chk(16'({irq_oe, irq_pin, irq_o}), 16'h0004);
      rd(OFS_WAKE_STAT, v);
      chk(16'(v[3:0]), 16'(w));
      wr(OFS_IRQ_EN, 16'h0000);
      tick(2);
      chk(16'({irq_oe, irq_pin}), 16'h0001);
      wr(OFS_WAKE_CLR, 16'h000F);
      wr(OFS_IRQ_CLR, 16'h0007);
      wr(OFS_IRQ_EN, 16'h0004);
      tick(2);
      chk(16'({wake_out, irq_oe, irq_pin}), 16'({~p, 2'b01}));
    end
    // Events that are not enabled leave the wake output idle
    wr(OFS_POWER_CTRL, 16'h0000);
    @(posedge ref_clk);
    wake_events <= 4'hF;
    @(posedge ref_clk);
    wake_events <= 4'h0;
    tick(3);
    chk(16'(wake_out), 16'h0001);
    // Link change interrupt
    wr(OFS_IRQ_EN, 16'h0001);
    @(posedge ref_clk);
    link.link_up <= 1'b0;
    tick(4);
    chk(16'({irq_oe, irq_pin}), 16'h0002);
    // Host strobes, read then write
    @(posedge ref_clk);
    host_rd <= 1'b1;
    tick(4);
    chk(16'({wr_act, rd_act}), 16'h0001);
    rd(OFS_PIN_STAT, v);
    chk(16'(v[7:6]), 16'h0001);
    @(posedge ref_clk);
    host_rd <= 1'b0;
    host_wr <= 1'b1;
    tick(4);
    chk(16'({wr_act, rd_act}), 16'h0002);
    @(posedge ref_clk);
    host_wr <= 1'b0;
    // Clock enable low freezes every pin; they catch up once it returns
    @(posedge ref_clk);
    ce           <= 1'b0;
    link.link_up <= 1'b1;
    tick(4);
    chk(16'({irq_oe, led2_o}), 16'h0003);
    @(posedge ref_clk);
    ce <= 1'b1;
    tick(2);
    chk(16'({irq_oe, led2_o}), 16'h0002);
    // EEPROM data pin is driven after reset, opposite to its pull
    @(posedge ref_clk);
    tx_en   <= 1'b1;
    tx_data <= 1'b1;
    tick(5);
    chk(16'({ee_oe, ee_pin, rx_data}), 16'h0007);
    test_done();
  end
endmodule
